// >>> hdl/ema_accum.sv
// energy metering accumulator: interval sums, rms, power, energy, flags
// assumes one sample strobe per converter sample, synchronous inputs,
// and a word register port fed by the serial host link
`timescale 1ns/1ns
`default_nettype none
module ema_accum #(
    parameter int SAMPLE_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic signed [SAMPLE_W-1:0] volt_a,
    input wire logic signed [SAMPLE_W-1:0] curr_a,
    input wire logic signed [SAMPLE_W-1:0] volt_b,
    input wire logic signed [SAMPLE_W-1:0] curr_b,
    input wire logic [10:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic pass_done_irq,
    output logic sag_irq
);
    import ema_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    ema_state_t state_q;
    logic [11:0] count_q;
    logic signed [63:0] acc_q [NUM_ACC];
    logic signed [63:0] acc_d [NUM_ACC];
    logic signed [31:0] stage_q [NUM_ACC];
    logic signed [SAMPLE_W-1:0] vprev_q [2];
    logic [31:0] setup_q;
    logic signed [31:0] vscale_q;
    logic signed [31:0] power_scale_param_q;
    logic [31:0] sag_thr_q;
    logic [SAG_DEBOUNCE_COUNT_W-1:0] sag_debounce_count_q [2];
    logic [1:0] sag_live_q;
    logic [1:0] sag_flag_q;
    logic line_clk_q;
    logic signed [31:0] vsq_q;
    logic signed [31:0] isq_q;
    logic signed [31:0] psum_q;
    logic signed [31:0] vrms_q;
    logic signed [31:0] power_q;
    logic signed [31:0] energy_q [2];
    logic signed [31:0] wsum_q;
    logic signed [31:0] varsum_q;
    logic [31:0] rd_d;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic irq_q;
    logic sag_irq_q;
    logic run;
    logic last;
    logic commit;
    logic signed [SAMPLE_W-1:0] vin [2];
    logic signed [SAMPLE_W-1:0] iin [2];

    ema_sqrt_if sq ();

    ema_sqrt u_sqrt (
        .clk(clk),
        .reset(reset),
        .sq(sq)
    );

    assign run = setup_q[SETUP_RUN_BIT];
    assign last = sample_valid && run &&
        (count_q == 12'(INTERVAL_SAMPLES - 1));
    assign commit = (state_q == ST_ROOT) && sq.done;
    assign vin[0] = volt_a;
    assign vin[1] = volt_b;
    assign iin[0] = curr_a;
    assign iin[1] = curr_b;
    assign sq.start = last;
    assign sq.radicand = ema_sat32(acc_d[K_VSQ] >>> ACC_SHIFT);
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign pass_done_irq = irq_q;
    assign sag_irq = sag_irq_q;

    function automatic logic signed [31:0] scale14(
        input logic signed [31:0] a, input logic signed [31:0] b);
        logic signed [63:0] p;
        p = 64'(a) * 64'(b);
        return ema_sat32(p >>> SCALE_SHIFT);
    endfunction

    function automatic logic [SAMPLE_W-1:0] mag(
        input logic signed [SAMPLE_W-1:0] v);
        return v[SAMPLE_W-1] ? SAMPLE_W'(-v) : v;
    endfunction

    function automatic logic [31:0] gain_sel(input logic slow,
        input logic fast);
        unique case ({slow, fast})
            2'b00: return GAIN_NORMAL;
            2'b01: return GAIN_FAST;
            2'b10: return GAIN_SLOW;
            2'b11: return GAIN_SLOW_FAST;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // interval counter and pass sequencing
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset || !run) begin
            count_q <= 12'h000;
        end else if (sample_valid) begin
            count_q <= last ? 12'h000 : count_q + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_ACCUM;
        end else begin
            unique case (state_q)
                ST_ACCUM: begin
                    if (last) begin
                        state_q <= ST_ROOT;
                    end
                end
                ST_ROOT: begin
                    if (sq.done) begin
                        state_q <= ST_ACCUM;
                    end
                end
                default: state_q <= ST_ACCUM;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // accumulators
    // ------------------------------------------------------------------
    always_comb begin
        acc_d[K_VSQ] = acc_q[K_VSQ] + 64'(volt_a) * 64'(volt_a);
        acc_d[K_ISQ] = acc_q[K_ISQ] + 64'(curr_a) * 64'(curr_a);
        acc_d[K_PA] = acc_q[K_PA] + 64'(volt_a) * 64'(curr_a);
        acc_d[K_PB] = acc_q[K_PB] + 64'(volt_b) * 64'(curr_b);
        // reactive term pairs current with the previous voltage sample
        acc_d[K_QA] = acc_q[K_QA] + 64'(vprev_q[0]) * 64'(curr_a);
        acc_d[K_QB] = acc_q[K_QB] + 64'(vprev_q[1]) * 64'(curr_b);
    end

    always_ff @(posedge clk) begin
        for (int k = 0; k < NUM_ACC; k++) begin
            if (reset || !run) begin
                acc_q[k] <= 64'sh0;
                stage_q[k] <= 32'sh0;
            end else if (sample_valid) begin
                acc_q[k] <= last ? 64'sh0 : acc_d[k];
                if (last) begin
                    // shift keeps a full second below half range
                    stage_q[k] <= ema_sat32(acc_d[k] >>> ACC_SHIFT);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int p = 0; p < 2; p++) begin
            if (reset) begin
                vprev_q[p] <= '0;
            end else if (sample_valid) begin
                vprev_q[p] <= vin[p];
            end
        end
    end

    // ------------------------------------------------------------------
    // result words, all loaded in the commit cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            vsq_q <= 32'sh0;
            isq_q <= 32'sh0;
            psum_q <= 32'sh0;
            vrms_q <= 32'sh0;
            power_q <= 32'sh0;
            energy_q[0] <= 32'sh0;
            energy_q[1] <= 32'sh0;
            wsum_q <= 32'sh0;
            varsum_q <= 32'sh0;
            sag_flag_q <= 2'b00;
        end else if (commit) begin
            vsq_q <= stage_q[K_VSQ];
            isq_q <= stage_q[K_ISQ];
            psum_q <= stage_q[K_PA];
            vrms_q <= scale14($signed({16'h0000, sq.root}), vscale_q);
            power_q <= scale14(stage_q[K_PA], power_scale_param_q);
            energy_q[0] <= stage_q[K_PA];
            energy_q[1] <= stage_q[K_PB];
            wsum_q <= ema_sat32(64'(stage_q[K_PA]) +
                64'(stage_q[K_PB]));
            varsum_q <= ema_sat32(64'(stage_q[K_QA]) +
                64'(stage_q[K_QB]));
            sag_flag_q <= sag_live_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= commit;
        end
    end

    // ------------------------------------------------------------------
    // sag detection and line-rate clock
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        for (int p = 0; p < 2; p++) begin
            if (reset) begin
                sag_debounce_count_q[p] <= '0;
                sag_live_q[p] <= 1'b0;
            end else if (sample_valid) begin
                if (32'(mag(vin[p])) >= sag_thr_q) begin
                    sag_debounce_count_q[p] <= '0;
                    sag_live_q[p] <= 1'b0;
                end else if (sag_debounce_count_q[p] !=
                    setup_q[SETUP_SAG_DEBOUNCE_COUNT_LSB +: SAG_DEBOUNCE_COUNT_W]) begin
                    sag_debounce_count_q[p] <= sag_debounce_count_q[p] + 1'b1;
                end else begin
                    sag_live_q[p] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sag_irq_q <= 1'b0;
        end else begin
            sag_irq_q <= setup_q[SETUP_SAG_INT_BIT] && sample_valid &&
                !sag_live_q[0] && (32'(mag(volt_a)) < sag_thr_q) &&
                (sag_debounce_count_q[0] == setup_q[SETUP_SAG_DEBOUNCE_COUNT_LSB +: SAG_DEBOUNCE_COUNT_W]);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            line_clk_q <= 1'b0;
        end else if (sample_valid &&
            (volt_a[SAMPLE_W-1] != vprev_q[0][SAMPLE_W-1])) begin
            line_clk_q <= ~line_clk_q;
        end
    end

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            setup_q <= SETUP_RESET;
            vscale_q <= VSCALE_RESET;
            power_scale_param_q <= POWER_SCALE_PARAM_RESET;
            sag_thr_q <= SAG_THR_RESET;
        end else if (reg_wr) begin
            // measurement words have no write path
            unique case (reg_addr)
                ADDR_SETUP: setup_q <= reg_wdata;
                ADDR_VSCALE: vscale_q <= reg_wdata;
                ADDR_POWER_SCALE_PARAM: power_scale_param_q <= reg_wdata;
                ADDR_SAG_THR: sag_thr_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_d = 32'h00000000;
        unique case (reg_addr)
            ADDR_SETUP: rd_d = setup_q;
            ADDR_PH0_ENERGY: rd_d = energy_q[0];
            ADDR_PH1_ENERGY: rd_d = energy_q[1];
            ADDR_FLAGS: begin
                rd_d[FLAG_SAG_A_BIT] = sag_flag_q[0];
                rd_d[FLAG_SAG_B_BIT] = sag_flag_q[1];
                rd_d[FLAG_LINE_CLK_BIT] = line_clk_q;
            end
            ADDR_VSQ: rd_d = vsq_q;
            ADDR_ISQ: rd_d = isq_q;
            ADDR_PSUM: rd_d = psum_q;
            ADDR_VRMS: rd_d = vrms_q;
            ADDR_POWER: rd_d = power_q;
            ADDR_WSUM: rd_d = wsum_q;
            ADDR_VARSUM: rd_d = varsum_q;
            ADDR_VSCALE: rd_d = vscale_q;
            ADDR_POWER_SCALE_PARAM: rd_d = power_scale_param_q;
            ADDR_SAG_THR: rd_d = sag_thr_q;
            ADDR_GAIN: rd_d = gain_sel(setup_q[SETUP_SLOW_BIT],
                setup_q[SETUP_FAST_BIT]);
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rd_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_count_wraps: assert property (last |=> count_q == 12'h000)
        else $error("interval counter did not wrap after last sample");
    a_acc_cleared: assert property (last |=> acc_q[K_VSQ] == 64'sh0)
        else $error("voltage square sum not cleared at boundary");
    a_vsq_adds: assert property (sample_valid && run && !last |=>
        acc_q[K_VSQ] == $past(acc_q[K_VSQ]) +
        64'($past(volt_a)) * 64'($past(volt_a)))
        else $error("voltage square sum missed a sample");
    a_root_bounded: assert property (last |-> ##[1:40] commit)
        else $error("result commit late after boundary");
    a_irq_pulse: assert property (commit |=> pass_done_irq ##1
        !pass_done_irq)
        else $error("pass done interrupt not a single pulse");
    a_results_hold: assert property (!commit |=> $stable(vrms_q) &&
        $stable(energy_q[0]) && $stable(wsum_q))
        else $error("result word changed outside commit");
    a_wsum_sum: assert property (commit |=> wsum_q ==
        ema_sat32(64'(energy_q[0]) + 64'(energy_q[1])))
        else $error("combined energy is not the phase sum");
    a_ro_write: assert property (reg_wr && reg_addr == ADDR_PH0_ENERGY &&
        !commit |=> energy_q[0] == $past(energy_q[0]))
        else $error("write reached a measurement word");
    a_sag_gated: assert property (sag_irq |->
        $past(setup_q[SETUP_SAG_INT_BIT]))
        else $error("sag interrupt while disabled");
    a_read_answer: assert property (reg_rd |=> reg_rvalid &&
        reg_rdata == $past(rd_d))
        else $error("read answer wrong or missing");

    c_commit: cover property (commit);
    c_sag: cover property (sag_irq);
    c_setup_write: cover property (reg_wr && reg_addr == ADDR_SETUP);

endmodule
`default_nettype wire

// >>> include/ema_pkg.sv
// energy metering accumulator: shared constants, register map, types
// assumes one 100 MHz clock and a word-wide register port behind the
// serial host link
package ema_pkg;

    // ------------------------------------------------------------------
    // register word addresses
    // ------------------------------------------------------------------
    localparam logic [10:0] ADDR_SETUP = 11'h020;
    localparam logic [10:0] ADDR_PH0_ENERGY = 11'h085;
    localparam logic [10:0] ADDR_PH1_ENERGY = 11'h086;
    localparam logic [10:0] ADDR_FLAGS = 11'h0A0;
    localparam logic [10:0] ADDR_VSQ = 11'h0A1;
    localparam logic [10:0] ADDR_ISQ = 11'h0A2;
    localparam logic [10:0] ADDR_PSUM = 11'h0A3;
    localparam logic [10:0] ADDR_VRMS = 11'h0A4;
    localparam logic [10:0] ADDR_POWER = 11'h0A5;
    localparam logic [10:0] ADDR_WSUM = 11'h0A6;
    localparam logic [10:0] ADDR_VARSUM = 11'h0A7;
    localparam logic [10:0] ADDR_VSCALE = 11'h0A8;
    localparam logic [10:0] ADDR_POWER_SCALE_PARAM = 11'h0A9;
    localparam logic [10:0] ADDR_SAG_THR = 11'h0AA;
    localparam logic [10:0] ADDR_GAIN = 11'h0AB;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SETUP_SAG_DEBOUNCE_COUNT_LSB = 0;
    localparam int SAG_DEBOUNCE_COUNT_W = 8;
    localparam int SETUP_FAST_BIT = 16;
    localparam int SETUP_SLOW_BIT = 17;
    localparam int SETUP_SAG_INT_BIT = 20;
    localparam int SETUP_RUN_BIT = 24;
    localparam int FLAG_SAG_A_BIT = 0;
    localparam int FLAG_SAG_B_BIT = 1;
    localparam int FLAG_LINE_CLK_BIT = 2;

    // ------------------------------------------------------------------
    // reset values and pulse gain constants (gains are arbitrary)
    // ------------------------------------------------------------------
    localparam logic [31:0] SETUP_RESET = 32'h00000000;
    localparam logic [31:0] VSCALE_RESET = 32'h00004000;
    localparam logic [31:0] POWER_SCALE_PARAM_RESET = 32'h00004000;
    localparam logic [31:0] SAG_THR_RESET = 32'h00000000;
    localparam logic [31:0] GAIN_NORMAL = 32'h00000001;
    localparam logic [31:0] GAIN_FAST = 32'h00000004;
    localparam logic [31:0] GAIN_SLOW = 32'h00000010;
    localparam logic [31:0] GAIN_SLOW_FAST = 32'h00000040;

    // ------------------------------------------------------------------
    // interval and scaling
    // ------------------------------------------------------------------
    localparam int INTERVAL_SAMPLES = 2520;
    localparam int SAMPLE_RATE_NUM = 32768;
    localparam int SAMPLE_RATE_DEN = 13;
    localparam int SCALE_SHIFT = 14;
    localparam int ACC_SHIFT = 12;
    localparam int NUM_ACC = 6;
    localparam int K_VSQ = 0;
    localparam int K_ISQ = 1;
    localparam int K_PA = 2;
    localparam int K_PB = 3;
    localparam int K_QA = 4;
    localparam int K_QB = 5;

    typedef enum logic [1:0] {
        ST_ACCUM = 2'b00,
        ST_ROOT = 2'b01
    } ema_state_t;

    // clamp a wide signed value into a signed 32-bit word
    function automatic logic signed [31:0] ema_sat32(
        input logic signed [63:0] v);
        if (v > 64'sh000000007FFFFFFF) begin
            return 32'sh7FFFFFFF;
        end
        if (v < -64'sh0000000080000000) begin
            return 32'sh80000000;
        end
        return v[31:0];
    endfunction

endpackage

// >>> include/ema_sqrt_if.sv
// square root request and answer between the accumulator and its root unit
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface ema_sqrt_if;
    logic start;
    logic [31:0] radicand;
    logic done;
    logic [15:0] root;
    modport client (output start, output radicand, input done, input root);
    modport engine (input start, input radicand, output done, output root);
endinterface
`default_nettype wire

// >>> hdl/ema_sqrt.sv
// iterative integer square root, one result bit per clock
// assumes start is a one-cycle pulse and not repeated while busy
`timescale 1ns/1ns
`default_nettype none
module ema_sqrt (
    input wire logic clk,
    input wire logic reset,
    ema_sqrt_if.engine sq
);
    import ema_pkg::*;

    logic [31:0] rem_q;
    logic [31:0] res_q;
    logic [31:0] one_q;
    logic busy_q;
    logic done_q;
    logic [31:0] trial;

    assign trial = res_q + one_q;
    assign sq.done = done_q;
    assign sq.root = res_q[15:0];

    always_ff @(posedge clk) begin
        if (reset) begin
            rem_q <= 32'h00000000;
            res_q <= 32'h00000000;
            one_q <= 32'h00000000;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (sq.start) begin
                rem_q <= sq.radicand;
                res_q <= 32'h00000000;
                one_q <= 32'h40000000;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (rem_q >= trial) begin
                    rem_q <= rem_q - trial;
                    res_q <= (res_q >> 1) + one_q;
                end else begin
                    res_q <= res_q >> 1;
                end
                one_q <= one_q >> 2;
                if (one_q == 32'h00000001) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> bench/ema_host.sv
// host controller model: word reads and writes on the register port
// assumes one caller at a time and the shared 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module ema_host
    import ema_pkg::*;
(
    input wire logic clk,
    output logic [10:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 11'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 32'h00000000;
    end
    // one strobe cycle; released data is scrambled so nothing leans on it
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [10:0] a, output logic [31:0] d,
                      output logic ok);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        ok = (reg_rvalid === 1'b1);
        d = reg_rdata;
    endtask
    // energy count to watt-hours, given the full-scale rms volts and amps
    function automatic real to_wh(input logic [31:0] cnt, input real vmax,
                                  input real imax);
        return 6.08040e-13 * vmax * imax * real'(signed'(cnt));
    endfunction
    // scales and threshold first, setup word with run bit last
    task automatic start(input logic [31:0] thr, input logic [31:0] setup);
        wr(ADDR_VSCALE, 32'h00004000);
        wr(ADDR_POWER_SCALE_PARAM, 32'h00004000);
        wr(ADDR_SAG_THR, thr);
        wr(ADDR_SETUP, setup);
    endtask
endmodule
`default_nettype wire

// >>> bench/ema_accum_tb.sv
// self-checking bench for the metering accumulator
// assumes the host model drives the register port
`timescale 1ns/1ns
`default_nettype none
module ema_accum_tb;
    import ema_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic sample_valid = 1'b0;
    logic signed [15:0] volt_a = 16'sh0000, curr_a = 16'sh0000;
    logic signed [15:0] volt_b = 16'sh0000, curr_b = 16'sh0000;
    logic [10:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, pass_done_irq, sag_irq;
    logic [31:0] reg_wdata, reg_rdata;
    int err_total = 0, comparisons = 0, irq_seen = 0, sag_seen = 0;
    logic [31:0] e_vsq, e_isq, e_pa, e_pb;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (pass_done_irq === 1'b1) irq_seen++;
        if (sag_irq === 1'b1) sag_seen++;
    end

    ema_accum #(.SAMPLE_W(16)) i_dut (.clk(clk), .reset(reset),
        .sample_valid(sample_valid), .volt_a(volt_a), .curr_a(curr_a),
        .volt_b(volt_b), .curr_b(curr_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pass_done_irq(pass_done_irq), .sag_irq(sag_irq));
    ema_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] sat(input longint v);
        if (v > 64'sh7FFFFFFF) return 32'h7FFFFFFF;
        if (v < -64'sh80000000) return 32'h80000000;
        return v[31:0];
    endfunction
    function automatic longint root(input longint x);
        longint r = 0;
        while ((r + 1) * (r + 1) <= x) r++;
        return r;
    endfunction
    // one interval's scaled sum of 2520 equal products
    function automatic logic [31:0] acc(input longint a, input longint b);
        return sat((64'sd2520 * a * b) >>> 12);
    endfunction
    task automatic summarize();
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, what,
                     seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [10:0] a, input logic [31:0] exp,
                          input logic [31:0] m);
        logic [31:0] d;
        logic ok;
        i_host.rd(a, d, ok);
        check({31'h0, ok}, 32'h1, "read answer");
        check(d & m, exp & m, "read word");
    endtask
    task automatic feed(input int v, input int i, input int n);
        repeat (n) begin
            repeat (15) @(posedge clk);
            #1;
            volt_a = v[15:0];
            curr_a = i[15:0];
            volt_b = v[15:0];
            curr_b = -i[15:0];
            sample_valid = 1'b1;
            @(posedge clk);
            #1;
            sample_valid = 1'b0;
        end
    endtask
    task automatic wait_irq(input int n);
        int k;
        for (k = 0; k < 200 && irq_seen < n; k++) @(posedge clk);
        if (irq_seen < n) begin
            check(irq_seen, n, "no pass done");
            summarize();
        end
        repeat (2) @(posedge clk);
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset_and_ro();
        rd_chk(ADDR_SETUP, 32'h0, 32'hFFFFFFFF);
        rd_chk(ADDR_VSCALE, 32'h00004000, 32'hFFFFFFFF);
        i_host.wr(ADDR_PH0_ENERGY, 32'h12345678);
        rd_chk(ADDR_PH0_ENERGY, 32'h0, 32'hFFFFFFFF);
        i_host.wr(ADDR_VSQ, 32'hFFFFFFFF);
        rd_chk(ADDR_VSQ, 32'h0, 32'hFFFFFFFF);
        rd_chk(11'h0FF, 32'h0, 32'hFFFFFFFF);
    endtask
    task automatic t_gain();
        logic [31:0] g [4] = '{GAIN_NORMAL, GAIN_FAST, GAIN_SLOW,
                                GAIN_SLOW_FAST};
        for (int k = 0; k < 4; k++) begin
            i_host.wr(ADDR_SETUP, 32'h00100000 | (32'(k) << 16));
            rd_chk(ADDR_GAIN, g[k], 32'hFFFFFFFF);
            rd_chk(ADDR_SETUP, 32'h00100000 | (32'(k) << 16),
                   32'hFFFFFFFF);
        end
        i_host.wr(ADDR_SETUP, 32'h0);
    endtask
    task automatic t_first_interval();
        i_host.start(32'h000007D0, 32'h01100002);
        feed(1000, 512, 2520);
        wait_irq(1);
        e_vsq = acc(1000, 1000);
        e_isq = acc(512, 512);
        e_pa = acc(1000, 512);
        e_pb = acc(1000, -512);
        rd_chk(ADDR_VSQ, e_vsq, 32'hFFFFFFFF);
        rd_chk(ADDR_ISQ, e_isq, 32'hFFFFFFFF);
        rd_chk(ADDR_PSUM, e_pa, 32'hFFFFFFFF);
        rd_chk(ADDR_VRMS, sat(root(e_vsq) * 16384 >>> 14),
               32'hFFFFFFFF);
        rd_chk(ADDR_POWER, sat(longint'(signed'(e_pa)) * 16384 >>> 14),
               32'hFFFFFFFF);
        rd_chk(ADDR_PH0_ENERGY, e_pa, 32'hFFFFFFFF);
        rd_chk(ADDR_PH1_ENERGY, e_pb, 32'hFFFFFFFF);
        rd_chk(ADDR_WSUM, sat(longint'(signed'(e_pa))
               + longint'(signed'(e_pb))), 32'hFFFFFFFF);
        rd_chk(ADDR_VARSUM, 32'h0, 32'hFFFFFFFF);
        check({31'h0, i_host.to_wh(e_pb, 1.0, 1.0) < 0.0}, 32'h1,
              "phase energy sign");
        rd_chk(ADDR_FLAGS, 32'h3, 32'h3);
        check(sag_seen, 1, "sag interrupt count");
    endtask
    task automatic t_second_interval();
        i_host.wr(ADDR_POWER_SCALE_PARAM, 32'h7FFFFFFF);
        feed(2000, 512, 1000);
        rd_chk(ADDR_VSQ, e_vsq, 32'hFFFFFFFF);
        rd_chk(ADDR_PH0_ENERGY, e_pa, 32'hFFFFFFFF);
        feed(2000, 512, 1520);
        wait_irq(2);
        rd_chk(ADDR_VSQ, acc(2000, 2000), 32'hFFFFFFFF);
        rd_chk(ADDR_POWER, 32'h7FFFFFFF, 32'hFFFFFFFF);
        rd_chk(ADDR_FLAGS, 32'h0, 32'h3);
        check(irq_seen, 2, "pass done count");
        feed(-100, 0, 1);
        rd_chk(ADDR_FLAGS, 32'h4, 32'h4);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset_and_ro();
        t_gain();
        t_first_interval();
        t_second_interval();
        summarize();
    end
endmodule
`default_nettype wire
